// file: logic/sssp_params.svh
// constants of the serial streaming register-access port
// Operation
// [RULE_01] msb-first frame opens with direction bit, then 15 address bits high to low
// [RULE_02] msb-first streaming: each data byte moves high bit first, 8 clocks per byte
// [RULE_03] lsb-first streaming: each data byte moves low bit first
// [RULE_04] counting down, bytes land at start, start-1, start-2, start-3
// [RULE_05] counting up, four bytes from 0x02A end at 0x02D
// [RULE_06] master holds chip select low through the whole stream, raises it after last bit
// [RULE_07] every data bit is captured on the serial clock rising edge
// [RULE_08] three-wire mode leaves the output line unused; read data on shared line
// [RULE_09] device changes its output bit after a serial clock falling edge
// [RULE_10] instruction bit 15 is 1 for read, 0 for write; bits 14:0 address
// [RULE_11] counting wraps: past last register to zero, below zero to last register
// [RULE_12] undefined addresses: writes dropped, reads return zeros, transfer continues
// [RULE_13] streaming disabled: one instruction and one data byte per frame
// [RULE_14] three-wire read: master releases shared line after last address bit
`ifndef SSSP_PARAMS_SVH
`define SSSP_PARAMS_SVH
`define SSSP_ADDR_W 15
`define SSSP_DATA_W 8
`define SSSP_CNT_W 4
`define SSSP_INSTR_LAST 4'hF
`define SSSP_BYTE_LAST 4'h7
`define SSSP_RW_BIT 15
`define SSSP_LAST_REG 15'h03FF
`define SSSP_ADDR_ZERO 15'h0000
`define SSSP_ADDR_ONE 15'h0001
`define SSSP_DATA_ZERO 8'h00
`endif

// file: logic/sssp_pkg.sv
// types of the serial streaming register-access port
`include "sssp_params.svh"
package sssp_pkg;
  typedef logic [`SSSP_ADDR_W-1:0] sssp_addr_t;
  typedef logic [`SSSP_DATA_W-1:0] sssp_data_t;
  typedef enum logic [2:0]
  {
    SSSP_IDLE = 3'h0,
    SSSP_INSTR = 3'h1,
    SSSP_WDATA = 3'h2,
    SSSP_RDATA = 3'h3,
    SSSP_DONE = 3'h4
  } sssp_state_t;
endpackage

// file: logic/sssp_buffer.sv
// two-entry valid/ready buffer, head entry always at index zero
`timescale 1ns/1ps
module sssp_buffer #(
  parameter int WIDTH = 23
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  logic [WIDTH-1:0] mem_ff [2];
  logic [1:0] count_ff;
  logic [1:0] nxt_count;
  logic push;
  logic pop;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_ff[0];

  always_comb
  begin
    nxt_count = count_ff;
    if (push && !pop)
      nxt_count = count_ff + 2'h1;
    else if (pop && !push)
      nxt_count = count_ff - 2'h1;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      count_ff <= 2'h0;
      out_valid_out <= 1'b0;
      in_ready_out <= 1'b1;
    end
    else
    begin
      count_ff <= nxt_count;
      out_valid_out <= (nxt_count != 2'h0);
      // ready drops once both entries hold words, so the source sees the stall
      in_ready_out <= (nxt_count != 2'h2);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (pop)
      mem_ff[0] <= mem_ff[1];
    if (push)
    begin
      if (count_ff == 2'h0 || (count_ff == 2'h1 && pop))
        mem_ff[0] <= in_data_in;
      else
        mem_ff[1] <= in_data_in;
    end
  end
endmodule // sssp_buffer

// file: logic/sssp_top.sv
// serial streaming register-access slave port, oversampled on the core clock
`timescale 1ns/1ps
`include "sssp_params.svh"
module sssp_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // serial pins from the baseband master
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n_out,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  // configuration
  input wire logic msb_first_order_in,
  input wire logic address_count_up_in,
  input wire logic streaming_enable_in,
  input wire logic four_wire_select_in,
  // write port toward the register file
  output logic wr_valid_out,
  output sssp_pkg::sssp_addr_t wr_addr_out,
  output sssp_pkg::sssp_data_t wr_data_out,
  input wire logic wr_ready_in,
  output logic wr_overflow_out,
  // read port toward the register file
  output sssp_pkg::sssp_addr_t rd_addr_out,
  output logic rd_strobe_out,
  input wire sssp_pkg::sssp_data_t rd_data_in
);
  import sssp_pkg::*;

  // ************************************************
  // pin synchronisers and edge detection
  // ************************************************
  logic cs_n_s1_ff, cs_n_s2_ff;
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic sdio_s1_ff, sdio_s2_ff;
  logic sclk_rise, sclk_fall, frame_on;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      cs_n_s1_ff <= 1'b1;
      cs_n_s2_ff <= 1'b1;
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      sdio_s1_ff <= 1'b0;
      sdio_s2_ff <= 1'b0;
    end
    else
    begin
      cs_n_s1_ff <= cs_n_in;
      cs_n_s2_ff <= cs_n_s1_ff;
      sclk_s1_ff <= sclk_in;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      sdio_s1_ff <= sdio_in;
      sdio_s2_ff <= sdio_s1_ff;
    end
  end

  // sdio shares the sclk delay, so it is sampled where the master meant
  assign frame_on = !cs_n_s2_ff;
  assign sclk_rise = frame_on && sclk_s2_ff && !sclk_s3_ff; // [RULE_07]
  assign sclk_fall = frame_on && !sclk_s2_ff && sclk_s3_ff; // [RULE_09]

  // ************************************************
  // frame sequencing
  // ************************************************
  sssp_state_t state_ff;
  logic [`SSSP_CNT_W-1:0] cnt_ff;
  logic [15:0] instr_ff;
  logic [15:0] nxt_instr;
  sssp_data_t wbyte_ff;
  sssp_data_t nxt_wbyte;
  sssp_addr_t addr_ff;
  sssp_addr_t nxt_addr_step;
  logic addr_defined;
  logic push_valid, push_ready;

  // both orders leave the direction bit at 15 and address bit 0 at 0
  assign nxt_instr = msb_first_order_in ? {instr_ff[14:0], sdio_s2_ff} // [RULE_01]
                                        : {sdio_s2_ff, instr_ff[15:1]};
  assign nxt_wbyte = msb_first_order_in ? {wbyte_ff[6:0], sdio_s2_ff} // [RULE_02]
                                        : {sdio_s2_ff, wbyte_ff[7:1]}; // [RULE_03]
  assign addr_defined = (addr_ff <= `SSSP_LAST_REG);

  always_comb
  begin
    nxt_addr_step = addr_ff;
    if (address_count_up_in)
      nxt_addr_step = (addr_ff >= `SSSP_LAST_REG) ? `SSSP_ADDR_ZERO : addr_ff + `SSSP_ADDR_ONE; // [RULE_05] [RULE_11]
    else
      nxt_addr_step = (addr_ff == `SSSP_ADDR_ZERO) ? `SSSP_LAST_REG : addr_ff - `SSSP_ADDR_ONE; // [RULE_04] [RULE_11]
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= SSSP_IDLE;
      cnt_ff <= 4'h0;
      instr_ff <= 16'h0000;
      wbyte_ff <= `SSSP_DATA_ZERO;
      addr_ff <= `SSSP_ADDR_ZERO;
    end
    else if (!frame_on)
    begin
      // raising chip select ends the frame wherever it stands
      state_ff <= SSSP_IDLE; // [RULE_06]
      cnt_ff <= 4'h0;
    end
    else
    begin
      case (state_ff)
        SSSP_IDLE:
        begin
          state_ff <= SSSP_INSTR;
          cnt_ff <= 4'h0;
        end
        SSSP_INSTR:
          if (sclk_rise)
          begin
            instr_ff <= nxt_instr;
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == `SSSP_INSTR_LAST)
            begin
              cnt_ff <= 4'h0;
              addr_ff <= nxt_instr[`SSSP_ADDR_W-1:0]; // [RULE_10]
              state_ff <= nxt_instr[`SSSP_RW_BIT] ? SSSP_RDATA : SSSP_WDATA; // [RULE_10]
            end
          end
        SSSP_WDATA, SSSP_RDATA:
          if (sclk_rise)
          begin
            wbyte_ff <= nxt_wbyte;
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == `SSSP_BYTE_LAST)
            begin
              cnt_ff <= 4'h0;
              if (streaming_enable_in)
                addr_ff <= nxt_addr_step;
              else
                state_ff <= SSSP_DONE; // [RULE_13]
            end
          end
        SSSP_DONE:
          state_ff <= SSSP_DONE; // [RULE_13]
        default:
          state_ff <= SSSP_IDLE;
      endcase
    end
  end

  // ************************************************
  // write path through the two-entry buffer
  // ************************************************
  // undefined addresses are never pushed, so their bits are lost
  assign push_valid = (state_ff == SSSP_WDATA) && sclk_rise && (cnt_ff == `SSSP_BYTE_LAST)
                      && addr_defined; // [RULE_12]

  // the master cannot be stalled; a word that finds the buffer full is flagged
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      wr_overflow_out <= 1'b0;
    else if (push_valid && !push_ready)
      wr_overflow_out <= 1'b1;
    else if (state_ff == SSSP_IDLE && frame_on)
      wr_overflow_out <= 1'b0;
  end

  sssp_buffer #(
    .WIDTH(`SSSP_ADDR_W + `SSSP_DATA_W)
  ) u_wr_buffer (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push_valid),
    .in_data_in({addr_ff, nxt_wbyte}),
    .in_ready_out(push_ready),
    .out_valid_out(wr_valid_out),
    .out_data_out({wr_addr_out, wr_data_out}),
    .out_ready_in(wr_ready_in)
  );

  // ************************************************
  // read path and pin drive
  // ************************************************
  sssp_data_t tx_ff;
  logic drive_bit_ff;
  logic drive_en_ff;
  logic load_byte;
  sssp_data_t load_val;

  assign load_byte = (state_ff == SSSP_RDATA) && sclk_fall && (cnt_ff == 4'h0);
  assign load_val = addr_defined ? rd_data_in : `SSSP_DATA_ZERO; // [RULE_12]

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      tx_ff <= `SSSP_DATA_ZERO;
      drive_bit_ff <= 1'b0;
      drive_en_ff <= 1'b0;
      rd_strobe_out <= 1'b0;
      rd_addr_out <= `SSSP_ADDR_ZERO;
    end
    else
    begin
      rd_strobe_out <= load_byte;
      rd_addr_out <= addr_ff;
      if (!frame_on)
        drive_en_ff <= 1'b0;
      else if (load_byte)
      begin
        tx_ff <= load_val;
        drive_bit_ff <= msb_first_order_in ? load_val[7] : load_val[0]; // [RULE_09]
        drive_en_ff <= 1'b1;
      end
      else if (sclk_fall && state_ff == SSSP_RDATA)
      begin
        tx_ff <= msb_first_order_in ? {tx_ff[6:0], 1'b0} : {1'b0, tx_ff[7:1]};
        drive_bit_ff <= msb_first_order_in ? tx_ff[6] : tx_ff[1]; // [RULE_02] [RULE_03] [RULE_09]
      end
      else if (sclk_fall && state_ff == SSSP_DONE)
        drive_en_ff <= 1'b0;
    end
  end

  // rd_addr_out lags addr_ff one cycle; the register file answers combinationally
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      sdio_out <= 1'b0;
      sdio_oe_n_out <= 1'b1;
      sdo_out <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end
    else
    begin
      sdio_out <= drive_bit_ff;
      sdo_out <= drive_bit_ff;
      sdio_oe_n_out <= !(drive_en_ff && !four_wire_select_in); // [RULE_08] [RULE_14]
      sdo_oe_n_out <= !(drive_en_ff && four_wire_select_in); // [RULE_08]
    end
  end
endmodule // sssp_top

// file: testbench/sssp_checker_asserts.sv
// concurrent checks on the pins and write port of the serial port
`timescale 1ns/1ps
module sssp_checker (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n_out,
  input wire logic sdo_out,
  input wire logic sdo_oe_n_out,
  input wire logic four_wire_select_in,
  // register file side
  input wire logic wr_valid_out,
  input wire sssp_pkg::sssp_addr_t wr_addr_out,
  input wire sssp_pkg::sssp_data_t wr_data_out,
  input wire logic wr_ready_in,
  input wire logic rd_strobe_out
);
  import sssp_pkg::*;
  // ********
  // checks
  // ********
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_sdo_unused_3w: assert property (!four_wire_select_in |-> sdo_oe_n_out)
    else $error("output line driven in three-wire mode");
  a_sdio_unused_4w: assert property (four_wire_select_in |-> sdio_oe_n_out)
    else $error("shared line driven in four-wire mode");
  a_idle_release: assert property (cs_n_in [*6] |-> sdio_oe_n_out && sdo_oe_n_out)
    else $error("data line still driven with chip select high");
  a_out_hold_high: assert property (sclk_in [*6] |-> $stable(sdo_out) && $stable(sdio_out))
    else $error("output bit changed while serial clock high");
  a_load_on_fall: assert property (rd_strobe_out |-> !sclk_in && !cs_n_in)
    else $error("read byte loaded outside a falling phase");
  a_strobe_pulse: assert property (rd_strobe_out |=> !rd_strobe_out)
    else $error("read strobe longer than one cycle");
  a_wr_word_hold: assert property (wr_valid_out && !wr_ready_in |=>
    wr_valid_out && $stable(wr_addr_out) && $stable(wr_data_out))
    else $error("write word changed before it was taken");
  a_wr_defined: assert property (wr_valid_out |-> wr_addr_out <= 15'h3FF)
    else $error("write to undefined address passed on");
  a_wr_on_rise: assert property ($rose(wr_valid_out) |-> sclk_in && !cs_n_in)
    else $error("write word appeared away from a rising edge");
endmodule // sssp_checker

// file: testbench/sssp_master_model.sv
// behavioural baseband master driving frames on the serial pins
`timescale 1ns/1ps
module sssp_master_model (
  // serial pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic data_out,
  output logic drive_out,
  input wire logic line_in
);
  // ********
  // frame
  // ********
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    data_out = 1'b0;
    drive_out = 1'b1;
  end
  // clock stands low between frames; 160 ns period, phase unrelated to the core clock
  task automatic xfer(input int n, input logic [63:0] bits, input int rel, output logic [63:0] rx);
    rx = '0;
    #3 cs_n_out = 1'b0;
    #80;
    for (int i = 0; i < n; i++)
    begin
      drive_out = (i < rel);
      data_out = bits[63-i];
      #80 sclk_out = 1'b1;
      rx = {rx[62:0], line_in};
      #80 sclk_out = 1'b0;
    end
    #80 cs_n_out = 1'b1;
    // the device lets go of the shared line a few core cycles after chip select rises
    #400;
    drive_out = 1'b1;
  endtask
endmodule // sssp_master_model

// file: testbench/tb_spi_slave_streaming_port.sv
// self-checking bench for the serial streaming port
`timescale 1ns/1ps
module tb_spi_slave_streaming_port;
  import sssp_pkg::*;
  logic clk = 1'b0;
  logic rst_n, cs_n, sclk, m_bit, m_drv, sdio_o, sdio_oe_n, sdo_o, sdo_oe_n;
  logic tog = 1'b0;
  logic msb, up, strm, fw, wr_valid, wr_rdy, ovf, rd_stb;
  sssp_addr_t wr_addr, rd_addr;
  sssp_data_t wr_data;
  logic [22:0] q[$];
  int error_cnt = 0;
  int comparisons = 0;
  // released lines float: modelled as a level that flips every cycle
  wire sdio_w = !sdio_oe_n ? sdio_o : m_drv ? m_bit : tog;
  wire sdo_w = !sdo_oe_n ? sdo_o : tog;
  wire sssp_data_t rd_data = rd_addr[7:0] ^ 8'hC3;
  // ********
  // clock, register file, instances
  // ********
  initial forever #4 clk = ~clk;
  always @(posedge clk) tog <= ~tog;
  always @(posedge clk) if (wr_valid === 1'b1 && wr_rdy === 1'b1) q.push_back({wr_addr, wr_data});
  sssp_master_model mdl (.cs_n_out(cs_n), .sclk_out(sclk), .data_out(m_bit), .drive_out(m_drv),
    .line_in(fw ? sdo_w : sdio_w));
  sssp_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .cs_n_in(cs_n), .sclk_in(sclk), .sdio_in(sdio_w),
    .sdio_out(sdio_o), .sdio_oe_n_out(sdio_oe_n), .sdo_out(sdo_o), .sdo_oe_n_out(sdo_oe_n),
    .msb_first_order_in(msb), .address_count_up_in(up), .streaming_enable_in(strm),
    .four_wire_select_in(fw), .wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
    .wr_ready_in(wr_rdy), .wr_overflow_out(ovf), .rd_addr_out(rd_addr), .rd_strobe_out(rd_stb),
    .rd_data_in(rd_data));
  // ********
  // helpers
  // ********
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cfg(input logic m, input logic u, input logic s, input logic f);
    @(negedge clk);
    {msb, up, strm, fw} = {m, u, s, f};
    q.delete();
  endtask
  // wire order: first bit sent sits at bit 63
  function automatic logic [63:0] bld(input logic m, input logic [15:0] ins, input logic [31:0] d);
    if (!m) ins = {<<{ins}};
    for (int i = 0; i < 4; i++) if (!m) d[8*i +: 8] = {<<{d[8*i +: 8]}};
    return {ins, d, 16'h0000};
  endfunction
  task wait_q(input int n);
    for (int k = 0; k < 200 && q.size() < n; k++) @(posedge clk);
    if (q.size() < n) error_cnt++;
    if (q.size() < n) report_and_stop();
  endtask
  task chk_words(input logic [14:0] a, input logic [31:0] d, input int n, input logic u);
    for (int i = 0; i < n; i++) chk(q[i], {u ? a + 15'(i) : a - 15'(i), d[31-8*i -: 8]});
  endtask
  task rd_chk(input logic m, input logic u, input logic s, input logic f, input logic [15:0] ins,
    input logic [15:0] e);
    logic [63:0] rx;
    logic [7:0] b;
    cfg(m, u, s, f);
    mdl.xfer(32, bld(m, ins, 32'h0), f ? 32 : 16, rx);
    b = rx[15:8];
    if (!m) b = {<<{rx[15:8]}};
    chk(b, e[15:8]);
    b = rx[7:0];
    if (!m) b = {<<{rx[7:0]}};
    if (s) chk(b, e[7:0]);
  endtask
  // ********
  // scenarios
  // ********
  task t_wr_down;
    logic [63:0] rx;
    cfg(1'b1, 1'b0, 1'b1, 1'b1);
    mdl.xfer(48, bld(1'b1, 16'h002A, 32'hA53C0FF0), 48, rx);
    wait_q(4);
    chk_words(15'h02A, 32'hA53C0FF0, 4, 1'b0);
  endtask
  task t_wr_up_lsb;
    logic [63:0] rx;
    cfg(1'b0, 1'b1, 1'b1, 1'b1);
    mdl.xfer(48, bld(1'b0, 16'h002A, 32'h12345678), 48, rx);
    wait_q(4);
    chk_words(15'h02A, 32'h12345678, 4, 1'b1);
  endtask
  // receiver stalls: two words buffered, the third is lost and flagged
  task t_stall;
    logic [63:0] rx;
    cfg(1'b1, 1'b1, 1'b1, 1'b1);
    wr_rdy = 1'b0;
    mdl.xfer(40, bld(1'b1, 16'h03FE, 32'h11223300), 40, rx);
    chk(ovf, 1'b1);
    chk(q.size(), 0);
    @(negedge clk);
    wr_rdy = 1'b1;
    wait_q(2);
    chk(q.size(), 2);
    chk_words(15'h3FE, 32'h11223300, 2, 1'b1);
  endtask
  task t_single;
    logic [63:0] rx;
    cfg(1'b1, 1'b1, 1'b0, 1'b1);
    mdl.xfer(32, bld(1'b1, 16'h0400, 32'hAAAA0000), 32, rx);
    mdl.xfer(32, bld(1'b1, 16'h0005, 32'h5A770000), 32, rx);
    wait_q(1);
    chk(q.size(), 1);
    chk(q[0], {15'h005, 8'h5A});
  endtask
  task t_reads;
    rd_chk(1'b1, 1'b1, 1'b0, 1'b1, 16'h800A, 16'hC900);
    rd_chk(1'b1, 1'b1, 1'b1, 1'b0, 16'h83FF, 16'h3CC3);
    rd_chk(1'b0, 1'b0, 1'b1, 1'b0, 16'h8000, 16'hC33C);
    rd_chk(1'b1, 1'b1, 1'b0, 1'b1, 16'h8400, 16'h0000);
  endtask
  task report_and_stop;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst_n, wr_rdy, msb, up, strm, fw} = 6'h16;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_wr_down;
    t_wr_up_lsb;
    t_stall;
    t_single;
    t_reads;
    report_and_stop();
  end
endmodule // tb_spi_slave_streaming_port
bind sssp_top sssp_checker chk_i (.core_clk_in, .rst_n_in, .cs_n_in, .sclk_in, .sdio_out, .sdio_oe_n_out,
  .sdo_out, .sdo_oe_n_out, .four_wire_select_in, .wr_valid_out, .wr_addr_out, .wr_data_out, .wr_ready_in,
  .rd_strobe_out);
